// *** rtl/pmt_pkg.sv ***
// Package for the period match timer: register map, field layout,
// reset values and timing constants.
// Assumes a 32-bit AHB-Lite register bus and one 200 MHz clock.
package pmt_pkg;

  // Byte offsets of the registers
  localparam logic [7:0] PMT_OFS_COUNT = 8'h00;
  localparam logic [7:0] PMT_OFS_PERIOD = 8'h04;
  localparam logic [7:0] PMT_OFS_CTRL = 8'h08;
  localparam logic [7:0] PMT_OFS_FLAGS = 8'h0C;
  localparam logic [7:0] PMT_OFS_ENABLES = 8'h10;

  // Control register fields
  localparam int PMT_CTRL_PRE_LSB = 0;
  localparam int PMT_CTRL_PRE_MSB = 1;
  localparam int PMT_CTRL_RUN_BIT = 2;
  localparam int PMT_CTRL_POST_LSB = 3;
  localparam int PMT_CTRL_POST_MSB = 6;
  localparam logic [7:0] PMT_CTRL_MASK = 8'h7F;

  // Flag and enable registers share this layout
  localparam int PMT_MATCH_BIT = 1;

  // Reset values
  localparam logic [7:0] PMT_COUNT_RESET = 8'h00;
  localparam logic [7:0] PMT_PERIOD_RESET = 8'hFF;
  localparam logic [7:0] PMT_CTRL_RESET = 8'h00;
  localparam logic [3:0] PMT_SCALER_RESET = 4'h0;

  // Prescale select codes
  localparam logic [1:0] PMT_PRE_DIV1 = 2'h0;
  localparam logic [1:0] PMT_PRE_DIV4 = 2'h1;
  localparam logic [1:0] PMT_PRE_LAST4 = 2'h3;
  localparam logic [3:0] PMT_PRE_LAST16 = 4'hF;

  // Instruction clock is the oscillator divided by this many cycles
  localparam int PMT_OSC_PER_INSTR = 4;
  localparam logic [1:0] PMT_PHASE_LAST = 2'(PMT_OSC_PER_INSTR - 1);

  // AHB encodings
  localparam logic [1:0] PMT_HTRANS_NONSEQ = 2'h2;
  localparam logic PMT_HRESP_OKAY = 1'b0;

endpackage

// *** rtl/pmt_timer.sv ***
// Period match timer: 8-bit count with prescaler, period compare,
// postscaled match flag and an AHB-Lite register slave.
// Assumes clk_in is the oscillator; the instruction clock is a quarter
// of it. One master, single word transfers only.
//
// Operation
// - While running, count rises by one per prescaled tick from zero.
// - A 4-bit prescale counter divides instruction ticks by 1, 4 or 16.
// - Prescale select 00 is /1, 01 is /4, 1x is /16.
// - Count is compared with period at each count tick; equality gives one match pulse.
// - After a match the count loads zero; the match clocks the postscaler.
// - Software reads and writes count and period at any time.
// - Reset clears the count and sets the period to all ones.
// - Count writes, control writes and reset clear both scaler counters.
// - A control write leaves the count unchanged.
// - Run enable in control bit 2 starts and stops counting.
// - Postscale select in bits 6 to 3 divides matches 1:1 to 1:16.
// - Each completed postscale division sets the match flag.
// - Interrupt goes out only when enabled; the flag latches regardless.
// - Control bit 7 reads zero and ignores writes; others reset to zero.
// - The unscaled match pulse is an output for compare and serial units.
//
// Added by the designer: the register offsets and register access over AHB-Lite.

`timescale 1ns/1ps
`default_nettype none

module pmt_timer
  import pmt_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic match_pulse_out,
  output logic irq_out
);

  // Bus state
  logic wr_pending;
  logic rd_pending;
  logic [7:0] ph_addr;
  logic bus_start;
  logic wr_count;
  logic wr_period;
  logic wr_ctrl;
  logic wr_flags;
  logic wr_enables;
  logic [7:0] wdata8;

  // Timer state
  logic [7:0] tick_count;
  logic [7:0] period_limit;
  logic [6:0] control;
  logic [1:0] instr_phase;
  logic [3:0] prescale_cnt;
  logic [3:0] postscale_cnt;
  logic match_flag;
  logic match_irq_enable;

  // Decoded control
  logic [1:0] prescale_select;
  logic [3:0] postscale_select;
  logic run_enable;
  logic instr_tick;
  logic count_tick;
  logic match;
  logic post_done;
  logic scaler_clear;
  logic [7:0] next_rdata;

  assign prescale_select = control[PMT_CTRL_PRE_MSB:PMT_CTRL_PRE_LSB];
  assign postscale_select = control[PMT_CTRL_POST_MSB:PMT_CTRL_POST_LSB];
  assign run_enable = control[PMT_CTRL_RUN_BIT];

  // hsize is accepted but unused: only whole words are transferred
  assign bus_start = hsel_in && hready_in &&
                     (htrans_in == PMT_HTRANS_NONSEQ) &&
                     (hsize_in == hsize_in);

  assign wdata8 = hwdata_in[7:0];
  assign wr_count = wr_pending && (ph_addr == PMT_OFS_COUNT);
  assign wr_period = wr_pending && (ph_addr == PMT_OFS_PERIOD);
  assign wr_ctrl = wr_pending && (ph_addr == PMT_OFS_CTRL);
  assign wr_flags = wr_pending && (ph_addr == PMT_OFS_FLAGS);
  assign wr_enables = wr_pending && (ph_addr == PMT_OFS_ENABLES);

  // Address phase capture; reads get one wait state so that a write
  // in the preceding data phase is already visible
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      wr_pending <= 1'b0;
      rd_pending <= 1'b0;
      ph_addr <= 8'h00;
    end else begin
      wr_pending <= bus_start && hwrite_in;
      rd_pending <= bus_start && !hwrite_in;
      if (bus_start) begin
        ph_addr <= haddr_in[7:0];
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      hreadyout_out <= 1'b1;
      hresp_out <= PMT_HRESP_OKAY;
    end else begin
      hreadyout_out <= !(bus_start && !hwrite_in);
      hresp_out <= PMT_HRESP_OKAY;
    end
  end

  // Read mux; unmapped offsets read zero, bit 7 of control reads zero
  always_comb begin
    next_rdata = 8'h00;
    case (ph_addr)
      PMT_OFS_COUNT: next_rdata = tick_count;
      PMT_OFS_PERIOD: next_rdata = period_limit;
      PMT_OFS_CTRL: next_rdata = {1'b0, control};
      PMT_OFS_FLAGS: next_rdata[PMT_MATCH_BIT] = match_flag;
      PMT_OFS_ENABLES: next_rdata[PMT_MATCH_BIT] = match_irq_enable;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      hrdata_out <= 32'h0000_0000;
    end else if (rd_pending) begin
      hrdata_out <= {24'h00_0000, next_rdata};
    end
  end

  // Instruction clock: one tick every fourth oscillator cycle
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      instr_phase <= 2'h0;
    end else begin
      instr_phase <= instr_phase + 2'h1;
    end
  end

  assign instr_tick = (instr_phase == PMT_PHASE_LAST);

  // Prescale completion
  always_comb begin
    count_tick = 1'b0;
    if (instr_tick && run_enable) begin
      if (prescale_select == PMT_PRE_DIV1) begin
        count_tick = 1'b1;
      end else if (prescale_select == PMT_PRE_DIV4) begin
        count_tick = (prescale_cnt[1:0] == PMT_PRE_LAST4);
      end else begin
        count_tick = (prescale_cnt == PMT_PRE_LAST16);
      end
    end
  end

  assign scaler_clear = wr_count || wr_ctrl;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      prescale_cnt <= PMT_SCALER_RESET;
    end else if (scaler_clear) begin
      prescale_cnt <= PMT_SCALER_RESET;
    end else if (instr_tick && run_enable) begin
      prescale_cnt <= prescale_cnt + 4'h1;
    end
  end

  // Comparison at each count tick; a match produces one pulse
  assign match = count_tick && (tick_count == period_limit);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      tick_count <= PMT_COUNT_RESET;
    end else if (wr_count) begin
      tick_count <= wdata8;
    end else if (match) begin
      tick_count <= PMT_COUNT_RESET;
    end else if (count_tick) begin
      tick_count <= tick_count + 8'h01;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      period_limit <= PMT_PERIOD_RESET;
    end else if (wr_period) begin
      period_limit <= wdata8;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      control <= PMT_CTRL_RESET[6:0];
    end else if (wr_ctrl) begin
      control <= wdata8[6:0] & PMT_CTRL_MASK[6:0];
    end
  end

  // Postscaler counts matches
  assign post_done = match && (postscale_cnt == postscale_select);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      postscale_cnt <= PMT_SCALER_RESET;
    end else if (scaler_clear) begin
      postscale_cnt <= PMT_SCALER_RESET;
    end else if (post_done) begin
      postscale_cnt <= PMT_SCALER_RESET;
    end else if (match) begin
      postscale_cnt <= postscale_cnt + 4'h1;
    end
  end

  // Sticky flag: cleared by writing zero, a new completion wins
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      match_flag <= 1'b0;
    end else if (post_done) begin
      match_flag <= 1'b1;
    end else if (wr_flags && !wdata8[PMT_MATCH_BIT]) begin
      match_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      match_irq_enable <= 1'b0;
    end else if (wr_enables) begin
      match_irq_enable <= wdata8[PMT_MATCH_BIT];
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irq_out <= 1'b0;
      match_pulse_out <= 1'b0;
    end else begin
      irq_out <= match_flag && match_irq_enable;
      match_pulse_out <= match;
    end
  end

endmodule

`default_nettype wire

// *** tb/pmt_timer_sva.sv ***
// Port checker for the period match timer.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none
module pmt_timer_sva
  import pmt_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  input wire logic match_pulse_out,
  input wire logic irq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  wire tk = hsel_in && hready_in && htrans_in == PMT_HTRANS_NONSEQ;
  wire rdt = tk && !hwrite_in;
  chk_rd_wait:
  assert property (rdt |=> !hreadyout_out ##1 hreadyout_out)
    else $error("read wait state wrong");
  chk_wr_nowait:
  assert property (tk && hwrite_in |=> hreadyout_out)
    else $error("write stalled");
  chk_resp_okay:
  assert property (hresp_out == PMT_HRESP_OKAY)
    else $error("response not okay");
  chk_rd_upper:
  assert property (hrdata_out[31:8] == 24'h0)
    else $error("upper read bits set");
  chk_ctrl_top:
  assert property (rdt && haddr_in[7:0] == PMT_OFS_CTRL |=> ##1 !hrdata_out[7])
    else $error("control bit 7 reads one");
  chk_unmapped_zero:
  assert property (rdt && haddr_in[7:0] == 8'h14 |=> ##1 hrdata_out == 32'h0)
    else $error("unmapped read not zero");
  chk_pulse_gap:
  assert property (match_pulse_out |=> !match_pulse_out [*3])
    else $error("match pulses too close");
  chk_reset_out:
  assert property ($fell(rst_in) |-> hreadyout_out && !irq_out && !match_pulse_out)
    else $error("outputs wrong after reset");
  cover property (match_pulse_out);
  cover property ($rose(irq_out));
  cover property (rdt);
endmodule
bind pmt_timer pmt_timer_sva pmt_timer_sva_i (.*);
`default_nettype wire

// *** tb/tb_top.sv ***
// Self-checking bench for the period match timer.
// Assumes the checker is bound; this module is the only bus master.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import pmt_pkg::*;
;
  logic clk_in = 0, rst_in = 1, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
  logic [1:0] htrans = 0;
  logic hrdy, hresp, pulse, irq;
  int errors = 0, total_checks = 0, cyc = 0, g, n, p, k;
  pmt_timer pmt_timer_i (.clk_in, .rst_in, .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hwdata_in(hwdata), .hready_in(hrdy), .hrdata_out(hrdata),
    .hreadyout_out(hrdy), .hresp_out(hresp), .match_pulse_out(pulse),
    .irq_out(irq));
  initial forever #2.5 clk_in = ~clk_in;
  task automatic conclude;
    $display("Checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      errors++;
      conclude;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    hsel <= 1;
    haddr <= {24'h0, a};
    htrans <= PMT_HTRANS_NONSEQ;
    hwrite <= wr;
    @(posedge clk_in);
    while (hrdy !== 1'b1) @(posedge clk_in);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk_in);
    while (hrdy !== 1'b1) @(posedge clk_in);
    q = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    ahb(0, a, 0);
    chk(q, e);
  endtask
  function automatic int dv(input logic [1:0] c);
    return c == PMT_PRE_DIV1 ? 1 : c == PMT_PRE_DIV4 ? 4 : 16;
  endfunction
  // Skips two pulses that may still come from the previous setting, then counts cycles to the next
  task automatic gap;
    repeat (2) begin
      @(posedge clk_in);
      while (pulse !== 1'b1) @(posedge clk_in);
    end
    @(posedge clk_in);
    g = 1;
    while (pulse !== 1'b1) begin
      @(posedge clk_in);
      g++;
    end
  endtask
  initial begin
    void'($urandom(47209));
    repeat (2) @(posedge clk_in);
    rst_in <= 0;
    @(posedge clk_in);
    rd(PMT_OFS_COUNT, 0);
    rd(PMT_OFS_PERIOD, 32'hFF);
    rd(PMT_OFS_CTRL, 0);
    rd(8'h14, 0);
    p = $urandom_range(255);
    ahb(1, PMT_OFS_COUNT, p);
    rd(PMT_OFS_COUNT, p);
    ahb(1, PMT_OFS_CTRL, 32'h83);
    rd(PMT_OFS_CTRL, 32'h3);
    repeat (40) @(posedge clk_in);
    rd(PMT_OFS_COUNT, p);
    for (int c = 0; c < 4; c++) begin
      p = $urandom_range(7);
      ahb(1, PMT_OFS_PERIOD, p);
      ahb(1, PMT_OFS_COUNT, 0);
      ahb(1, PMT_OFS_CTRL, 32'h4 | c);
      gap;
      chk(g, (p + 1) * dv(2'(c)) * PMT_OSC_PER_INSTR);
    end
    k = $urandom_range(15);
    ahb(1, PMT_OFS_CTRL, 0);
    ahb(1, PMT_OFS_PERIOD, 0);
    ahb(1, PMT_OFS_FLAGS, 0);
    ahb(1, PMT_OFS_ENABLES, 32'h2);
    ahb(1, PMT_OFS_COUNT, 0);
    ahb(1, PMT_OFS_CTRL, 32'h4 | (k << PMT_CTRL_POST_LSB));
    n = 0;
    while (irq !== 1'b1) begin
      @(posedge clk_in);
      if (pulse === 1'b1) n++;
    end
    chk(n, k + 1);
    ahb(1, PMT_OFS_CTRL, 0);
    ahb(1, PMT_OFS_ENABLES, 0);
    repeat (2) @(posedge clk_in);
    chk(irq, 0);
    rd(PMT_OFS_FLAGS, 32'h2);
    ahb(1, PMT_OFS_FLAGS, 0);
    rd(PMT_OFS_FLAGS, 0);
    conclude;
  end
endmodule
`default_nettype wire
